// >>> pkg/eiac_pkg.sv
package eiac_pkg;

	// Clock rates and the fractional step that turns the 250 MHz clock into 80 MHz core ticks.
	localparam int        CLK_HZ      = 250_000_000;
	localparam int        CORE_HZ     = 80_000_000;
	localparam logic [4:0] CORE_STEP  = 5'(CORE_HZ / 10_000_000);
	localparam logic [4:0] CORE_MOD   = 5'(CLK_HZ / 10_000_000);

	// Shortest start-to-stop separation the interval timer resolves, and its cycle count.
	localparam int MIN_SEP_NS  = 50;
	localparam int MIN_SEP_CYC = (MIN_SEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Seconds scaling: Q16.16 seconds = ticks * divisor * SEC_Q16_K / 2^32, K = 2^48 / 80e6.
	localparam logic [21:0] SEC_Q16_K = 22'h35afe5;

	// Register map; per-line and per-timebase registers sit in pages of sixteen words.
	localparam logic [15:0] ADDR_SYS_TICK = 16'hf050;
	localparam logic [15:0] ADDR_CAPTURE  = 16'h3100;
	localparam logic [3:0]  LINE_PAGE     = 4'h2;
	localparam logic [3:0]  TB_PAGE       = 4'h3;
	localparam logic [3:0]  F_SWITCH      = 4'h0;
	localparam logic [3:0]  F_CODE        = 4'h1;
	localparam logic [3:0]  F_TBSEL       = 4'h2;
	localparam logic [3:0]  F_POLARITY    = 4'h3;
	localparam logic [3:0]  F_RESULT      = 4'h4;
	localparam logic [3:0]  F_RESULT_SEC  = 4'h5;
	localparam logic [3:0]  F_RESULT_RC   = 4'h6;
	localparam logic [3:0]  F_TB_ENABLE   = 4'h0;
	localparam logic [3:0]  F_TB_DIVISOR  = 4'h1;
	localparam logic [3:0]  F_TB_WRAP     = 4'h2;

	// Feature codes and timebase select codes.
	localparam logic [7:0] FC_INTERVAL = 8'h06;
	localparam logic [7:0] FC_TALLY    = 8'h07;
	localparam logic [7:0] FC_IRQ_CNT  = 8'h08;
	localparam logic [2:0] TB_ZERO     = 3'h0;
	localparam logic [2:0] TB_ONE      = 3'h1;
	localparam logic [2:0] TB_TWO      = 3'h2;
	localparam int         NUM_TB      = 3;

	// Lines that carry the four hardware edge tallies.
	localparam int TALLY_A_LINE = 4;
	localparam int TALLY_B_LINE = 5;
	localparam int TALLY_C_LINE = 6;
	localparam int TALLY_D_LINE = 7;

	// Reset values.
	localparam logic [8:0]  RST_DIVISOR = 9'h000;
	localparam logic [31:0] RST_WRAP    = 32'h0;

	typedef enum logic [1:0] {IV_OFF, IV_WAIT_START, IV_WAIT_STOP, IV_DONE} eiac_iv_t;

	// Divisor to shift amount; zero and any unlisted value act as a divisor of one.
	function automatic logic [3:0] divShift(input logic [8:0] d);
		unique case (d)
			9'h002: divShift = 4'h1;
			9'h004: divShift = 4'h2;
			9'h008: divShift = 4'h3;
			9'h010: divShift = 4'h4;
			9'h020: divShift = 4'h5;
			9'h040: divShift = 4'h6;
			9'h100: divShift = 4'h8;
			default: divShift = 4'h0;
		endcase
	endfunction

endpackage

// >>> rtl/eiac_edge_sync.sv
`timescale 1ns/1ns
module eiac_edge_sync #(
	parameter int N = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] pins,
	output logic      [N-1:0] rise,
	output logic      [N-1:0] fall
);
	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] stab;
		logic [N-1:0] last;
		logic [1:0]   warm;
	} eiac_sync_t;

	eiac_sync_t s;
	eiac_sync_t next_s;
	logic       primed;

	// Two flops resolve metastability; only the second one feeds the edge compare.
	always_comb begin
		next_s      = s;
		next_s.meta = pins;
		next_s.stab = s.meta;
		next_s.last = s.stab;
		next_s.warm = (s.warm == 2'h3) ? s.warm : s.warm + 2'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// One physical edge gives one single-cycle pulse. Reset clears last, so a line that
	// idles high would look like a rise; edges stay masked until three clocks of history.
	assign primed = s.warm == 2'h3;
	assign rise   = (s.stab & ~s.last) & {N{primed}};
	assign fall   = (~s.stab & s.last) & {N{primed}};

	property p_single_pulse;
		@(posedge clk) disable iff (rst)
		rise != '0 |=> (rise & $past(rise)) == '0;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("Edge pulse lasted two cycles.");
endmodule

// >>> rtl/eiac_timebase.sv
`timescale 1ns/1ns
module eiac_timebase
	import eiac_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       coreTick,
	input  wire logic       enable,
	input  wire logic [8:0] divisor,
	output logic            tick
);
	typedef struct packed {
		logic [7:0] pre;
		logic       tick;
	} eiac_tb_t;

	eiac_tb_t   s;
	eiac_tb_t   next_s;
	logic [7:0] limit;

	// Count core ticks up to the divisor; a stopped timebase restarts from zero.
	always_comb begin
		limit       = 8'((9'h001 << divShift(divisor)) - 9'h001);
		next_s      = s;
		next_s.tick = 1'b0;
		if (!enable) begin
			next_s.pre = 8'h00;
		end else if (coreTick) begin
			if (s.pre >= limit) begin
				next_s.pre  = 8'h00;
				next_s.tick = 1'b1;
			end else begin
				next_s.pre = s.pre + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule

// >>> rtl/eiac_top.sv
`timescale 1ns/1ns
// Contract
// - Timebase select codes 000, 001, 010.
// - Polarity 0 falling, 1 rising edge.
// - Start edge, then stop edge, store ticks.
// - Result reads zero until pair seen.
// - Both interval lines read one value.
// - Seconds result scales ticks by frequency.
// - Read-clear returns value, zeroes, rearms.
// - One capture, then wait for rearm.
// - Resolve separations down to 50 ns.
// - Four tallies count rising edges, code 7.
// - Tallies A, B, D blocked when shared.
// - Read-clear returns count then zeroes it.
// - Stream reads low half, capture high.
// - Code 8 counts rising edges too.
// - Free-running 32-bit tick at 40 MHz.
// - Feature switch 0 off, 1 on.
// - Configuration frozen while feature is on.
// - Tick rate is core over divisor; a divisor of 128 ticks at the core rate.
// - Wrap value zero gives full range.
module eiac_top
	import eiac_pkg::*;
#(
	parameter int NL = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [NL-1:0] linePins,
	input  wire logic          streamActive,
	input  wire logic [15:0]   regAddr,
	input  wire logic          regRead,
	input  wire logic          regWrite,
	input  wire logic [31:0]   regWdata,
	output logic      [31:0]   regRdata,
	output logic               regRvalid
);
	typedef struct packed {
		logic [NL-1:0]              lineOn;
		logic [NL-1:0][7:0]         code;
		logic [NL-1:0][2:0]         tbSel;
		logic [NL-1:0]              pol;
		logic [NL-1:0][31:0]        count;
		logic [NUM_TB-1:0]          tbOn;
		logic [NUM_TB-1:0][8:0]     tbDiv;
		logic [NUM_TB-1:0][31:0]    tbWrap;
		eiac_iv_t                   iv;
		logic                       ivFirst;
		logic [31:0]                ivTicks;
		logic [31:0]                ivResult;
		logic [4:0]                 coreAcc;
		logic                       coreHalf;
		logic [31:0]                sysTick;
		logic [15:0]                capture;
		logic [31:0]                rdata;
		logic                       rvalid;
	} eiac_state_t;

	eiac_state_t        s;
	eiac_state_t        next_s;
	logic [NL-1:0]      rise;
	logic [NL-1:0]      fall;
	logic [NUM_TB-1:0]  tbTick;
	logic               coreTick;
	logic               linePage;
	logic               tbPage;
	int                 ix;
	logic [3:0]         field;
	logic               ivReady;
	logic               startEdge;
	logic               stopEdge;
	logic [2:0]         ivSel;
	logic               ivTick;
	logic [31:0]        ivNext;
	logic [31:0]        ivCapture;
	logic               rcIv;
	logic [NL-1:0]      lineInc;
	logic [NL-1:0]      lineClr;
	logic [31:0]        rdValue;
	logic [31:0]        secValue;
	logic [39:0]        secTicks;
	logic [63:0]        secProd;
	logic               resultRead;

	// Line inputs are synchronised and reduced to edge pulses.
	eiac_edge_sync #(
		.N(NL)
	) eiac_edge_sync_i (
		.clk (clk),
		.rst (rst),
		.pins(linePins),
		.rise(rise),
		.fall(fall)
	);

	// Three timebases, each a divided copy of the core tick.
	genvar g;
	generate
		for (g = 0; g < NUM_TB; g++) begin : g_tb
			eiac_timebase eiac_timebase_i (
				.clk     (clk),
				.rst     (rst),
				.coreTick(coreTick),
				.enable  (s.tbOn[g]),
				.divisor (s.tbDiv[g]),
				.tick    (tbTick[g])
			);
		end
	endgenerate

	// The fractional accumulator fires 8 times in 25 clocks, an 80 MHz average.
	assign coreTick = s.coreAcc >= 5'(CORE_MOD - CORE_STEP);

	// Address decode shared by reads and writes.
	assign linePage = regAddr[15:12] == LINE_PAGE && int'(regAddr[11:4]) < NL;
	assign tbPage   = regAddr[15:12] == TB_PAGE && int'(regAddr[11:4]) < NUM_TB;
	assign ix       = int'(regAddr[11:4]);
	assign field    = regAddr[3:0];

	// Interval timer steering; the line enabled first is the start line.
	assign ivReady   = NL >= 2 && s.lineOn[0] && s.lineOn[1]
	                   && s.code[0] == FC_INTERVAL && s.code[1] == FC_INTERVAL;
	assign startEdge = s.pol[s.ivFirst] ? rise[s.ivFirst] : fall[s.ivFirst];
	assign stopEdge  = s.pol[!s.ivFirst] ? rise[!s.ivFirst] : fall[!s.ivFirst];
	assign ivSel     = s.tbSel[s.ivFirst];
	assign ivTick    = (ivSel == TB_ZERO || ivSel == TB_ONE || ivSel == TB_TWO)
	                   && tbTick[ivSel[1:0]];
	// A nonzero wrap value shortens the range; zero lets the count run the full 32 bits.
	assign ivNext    = (s.tbWrap[ivSel[1:0]] != 32'h0
	                   && s.ivTicks + 32'h1 >= s.tbWrap[ivSel[1:0]]) ? 32'h0
	                   : s.ivTicks + 32'h1;
	assign ivCapture = ivTick ? ivNext : s.ivTicks;
	assign rcIv      = regRead && linePage && field == F_RESULT_RC && ix < 2
	                   && s.code[ix] == FC_INTERVAL;
	assign resultRead = linePage && (field == F_RESULT || field == F_RESULT_RC);

	// Seconds in Q16.16: scale ticks up by the divisor, then by the reciprocal of 80 MHz.
	assign secTicks = 40'(s.ivResult) << divShift(s.tbDiv[ivSel[1:0]]);
	assign secProd  = 64'(secTicks) * 64'(SEC_Q16_K);
	assign secValue = secProd[63:32];

	// Per-line counting and clearing; a read-clear keeps an edge from the same cycle.
	always_comb begin
		for (int l = 0; l < NL; l++) begin
			lineInc[l] = s.lineOn[l] && rise[l]
			             && ((s.code[l] == FC_TALLY
			                  && ((l == TALLY_A_LINE && !s.tbOn[0] && !s.tbOn[1])
			                   || (l == TALLY_B_LINE && !s.tbOn[0] && !s.tbOn[2])
			                   || l == TALLY_C_LINE
			                   || (l == TALLY_D_LINE && !streamActive)))
			              || s.code[l] == FC_IRQ_CNT);
			lineClr[l] = (regRead && linePage && ix == l && field == F_RESULT_RC)
			             || (regWrite && linePage && ix == l && field == F_SWITCH
			                 && regWdata[0] && !s.lineOn[l]);
		end
	end

	// Read multiplexer; unmapped addresses and reserved bits read as zero.
	always_comb begin
		rdValue = 32'h0;
		if (regAddr == ADDR_SYS_TICK) begin
			rdValue = s.sysTick;
		end else if (regAddr == ADDR_CAPTURE) begin
			rdValue = {16'h0, s.capture};
		end else if (linePage) begin
			unique case (field)
				F_SWITCH:   rdValue = {31'h0, s.lineOn[ix]};
				F_CODE:     rdValue = {24'h0, s.code[ix]};
				F_TBSEL:    rdValue = {29'h0, s.tbSel[ix]};
				F_POLARITY: rdValue = {31'h0, s.pol[ix]};
				F_RESULT, F_RESULT_RC:
					rdValue = (ix < 2 && s.code[ix] == FC_INTERVAL) ? s.ivResult
					          : (s.code[ix] == FC_TALLY || s.code[ix] == FC_IRQ_CNT)
					          ? s.count[ix] : 32'h0;
				F_RESULT_SEC:
					rdValue = (ix < 2 && s.code[ix] == FC_INTERVAL) ? secValue : 32'h0;
				default: rdValue = 32'h0;
			endcase
		end else if (tbPage) begin
			unique case (field)
				F_TB_ENABLE:  rdValue = {31'h0, s.tbOn[ix]};
				F_TB_DIVISOR: rdValue = {23'h0, s.tbDiv[ix]};
				F_TB_WRAP:    rdValue = s.tbWrap[ix];
				default:      rdValue = 32'h0;
			endcase
		end
	end

	// Next-state logic for the whole block.
	always_comb begin
		next_s        = s;
		next_s.rvalid = 1'b0;
		// Core tick and the half-rate system tick.
		next_s.coreAcc = coreTick ? 5'(s.coreAcc + CORE_STEP - CORE_MOD)
		                          : 5'(s.coreAcc + CORE_STEP);
		if (coreTick) begin
			next_s.coreHalf = ~s.coreHalf;
			if (s.coreHalf) begin
				next_s.sysTick = s.sysTick + 32'h1;
			end
		end
		// Line register writes; the feature settings only move while the switch is off.
		if (regWrite && linePage) begin
			unique case (field)
				F_SWITCH: begin
					next_s.lineOn[ix] = regWdata[0];
					if (regWdata[0] && ix < 2 && !s.lineOn[1 - ix]) begin
						next_s.ivFirst = ix[0];
					end
				end
				F_CODE: begin
					if (!s.lineOn[ix]) begin
						next_s.code[ix] = regWdata[7:0];
					end
				end
				F_TBSEL: begin
					if (!s.lineOn[ix]) begin
						next_s.tbSel[ix] = regWdata[2:0];
					end
				end
				F_POLARITY: begin
					if (!s.lineOn[ix]) begin
						next_s.pol[ix] = regWdata[0];
					end
				end
				default: ;
			endcase
		end
		// Timebase register writes.
		if (regWrite && tbPage) begin
			unique case (field)
				F_TB_ENABLE:  next_s.tbOn[ix]   = regWdata[0];
				F_TB_DIVISOR: next_s.tbDiv[ix]  = regWdata[8:0];
				F_TB_WRAP:    next_s.tbWrap[ix] = regWdata;
				default: ;
			endcase
		end
		// Edge tallies: a clear that meets an edge leaves a count of one.
		for (int l = 0; l < NL; l++) begin
			if (lineClr[l]) begin
				next_s.count[l] = {31'h0, lineInc[l]};
			end else if (lineInc[l]) begin
				next_s.count[l] = s.count[l] + 32'h1;
			end
		end
		// One-shot interval; stop is watched from the cycle after start, so the floor is one clock.
		unique case (s.iv)
			IV_OFF: begin
				if (ivReady) begin
					next_s.iv       = IV_WAIT_START;
					next_s.ivTicks  = 32'h0;
					next_s.ivResult = 32'h0;
				end
			end
			IV_WAIT_START: begin
				if (startEdge) begin
					next_s.iv      = IV_WAIT_STOP;
					next_s.ivTicks = 32'h0;
				end
			end
			IV_WAIT_STOP: begin
				if (ivTick) begin
					next_s.ivTicks = ivNext;
				end
				if (stopEdge) begin
					next_s.iv       = IV_DONE;
					next_s.ivResult = ivCapture;
				end
			end
			IV_DONE: begin
				if (rcIv) begin
					next_s.iv       = IV_WAIT_START;
					next_s.ivResult = 32'h0;
				end
			end
		endcase
		if (!ivReady) begin
			next_s.iv = IV_OFF;
		end
		// Read answer; during streaming integer results return their low half only.
		if (regRead) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rdValue;
			if (streamActive && resultRead) begin
				next_s.rdata   = {16'h0, rdValue[15:0]};
				next_s.capture = rdValue[31:16];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s        <= '0;
			s.iv     <= IV_OFF;
			s.tbDiv  <= {NUM_TB{RST_DIVISOR}};
			s.tbWrap <= {NUM_TB{RST_WRAP}};
		end else begin
			s <= next_s;
		end
	end

	assign regRdata  = s.rdata;
	assign regRvalid = s.rvalid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_stop_seen;
		s.iv == IV_WAIT_STOP && stopEdge && ivReady;
	endsequence
	sequence s_done_cleared;
		s.iv == IV_DONE && rcIv && ivReady && !streamActive && !regWrite;
	endsequence

	property p_zero_pending;
		s.iv == IV_WAIT_START || s.iv == IV_WAIT_STOP |-> s.ivResult == 32'h0;
	endproperty
	a_zero_pending: assert property (p_zero_pending) else $error("Result not zero.");
	property p_capture;
		s_stop_seen |=> s.iv == IV_DONE && s.ivResult == $past(ivCapture);
	endproperty
	a_capture: assert property (p_capture) else $error("Interval not stored.");
	property p_oneshot;
		s.iv == IV_DONE && !rcIv && ivReady && !regWrite |=> s.iv == IV_DONE ##0 $stable(s.ivResult);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("Measurement restarted.");
	property p_read_clear;
		s_done_cleared |=> regRvalid && regRdata == $past(s.ivResult) && s.ivResult == 32'h0
		                   && s.iv == IV_WAIT_START;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("Read-clear failed.");
	property p_polarity;
		s.iv == IV_WAIT_START && ivReady && !s.pol[s.ivFirst] && rise[s.ivFirst] && !regWrite
		|=> s.iv == IV_WAIT_START;
	endproperty
	a_polarity: assert property (p_polarity) else $error("Wrong edge started timer.");
	property p_tally_c;
		lineInc[TALLY_C_LINE] && !lineClr[TALLY_C_LINE]
		|=> s.count[TALLY_C_LINE] == $past(s.count[TALLY_C_LINE]) + 32'h1;
	endproperty
	a_tally_c: assert property (p_tally_c) else $error("Tally missed an edge.");
	property p_tally_a_blocked;
		s.tbOn[0] && !lineClr[TALLY_A_LINE] && s.code[TALLY_A_LINE] == FC_TALLY
		|=> $stable(s.count[TALLY_A_LINE]);
	endproperty
	a_tally_a_blocked: assert property (p_tally_a_blocked) else $error("Shared tally ran.");
	property p_stream_low;
		regRead && streamActive && resultRead
		|=> regRdata[31:16] == 16'h0 && s.capture == $past(rdValue[31:16]);
	endproperty
	a_stream_low: assert property (p_stream_low) else $error("Stream read not split.");
	// The first step after reset takes eight edges, so attempts start one edge after release.
	property p_systick;
		!$past(rst) |-> ##[1:7] s.sysTick != $past(s.sysTick);
	endproperty
	a_systick: assert property (p_systick) else $error("System tick stalled.");
	property p_frozen;
		regWrite && linePage && field == F_CODE && s.lineOn[ix] |=> $stable(s.code);
	endproperty
	a_frozen: assert property (p_frozen) else $error("Code changed while on.");
endmodule

// >>> testbench/eiac_line_model.sv
`timescale 1ns/1ns
// Stands in for the outside signals wired to the monitored lines.
module eiac_line_model (
	input  wire logic       clk,
	output logic      [7:0] lines
);

	// The start line idles high so that its first move is a fall; all others idle low.
	initial lines = 8'h01;

	// Each level is held at least five clocks, though the synchroniser catches any level held for one clock.
	task automatic setLine(input int idx, input logic v);
		@(posedge clk);
		lines[idx] <= v;
		repeat (4) @(posedge clk);
	endtask

	// One high pulse gives one rising edge followed by one falling edge.
	task automatic pulse(input int idx);
		setLine(idx, 1'b1);
		setLine(idx, 1'b0);
	endtask

endmodule

// >>> testbench/edge_interval_and_counters_tb.sv
`timescale 1ns/1ns
module edge_interval_and_counters_tb
	import eiac_pkg::*;
();

	logic        clk;
	logic        rst;
	logic [7:0]  linePins;
	logic        streamActive;
	logic [15:0] regAddr;
	logic        regRead;
	logic        regWrite;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic        regRvalid;
	int          miscompares;
	int          checks;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] c;
	logic [63:0] s;
	logic [31:0] e1 [4] = '{32'h0, 32'h0, 32'h2, 32'h0};
	logic [31:0] e2 [4] = '{32'h2, 32'h2, 32'h4, 32'h2};

	// Free-running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	eiac_top #(.NL(8)) eiac_top_i (
		.clk          (clk),
		.rst          (rst),
		.linePins     (linePins),
		.streamActive (streamActive),
		.regAddr      (regAddr),
		.regRead      (regRead),
		.regWrite     (regWrite),
		.regWdata     (regWdata),
		.regRdata     (regRdata),
		.regRvalid    (regRvalid)
	);

	eiac_line_model eiac_line_model_i (
		.clk   (clk),
		.lines (linePins)
	);

	// Addresses of per-line and per-timebase registers.
	function automatic logic [15:0] la(input int l, input logic [3:0] f);
		return {LINE_PAGE, 4'h0, 4'(l), f};
	endfunction
	function automatic logic [15:0] ta(input int t, input logic [3:0] f);
		return {TB_PAGE, 4'h0, 4'(t), f};
	endfunction

	// Compare one value and count it.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Range test, done as a flag so an unknown value never passes.
	task automatic chkRange(input string what, input logic [31:0] v, input logic [31:0] lo,
			input logic [31:0] hi);
		chk(what, {31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask

	task automatic wr(input logic [15:0] ad, input logic [31:0] v);
		@(posedge clk);
		regAddr  <= ad;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// The answer is registered on the taking edge and lasts one cycle, so it is looked at mid-cycle.
	task automatic rd(input logic [15:0] ad, output logic [31:0] v);
		@(posedge clk);
		regAddr <= ad;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk("read answer strobe", {31'h0, regRvalid}, 32'h1);
		v = regRdata;
	endtask

	// Switch off before changing the code, then switch on again.
	task automatic cfg(input int l, input logic [7:0] code, input logic pol);
		wr(la(l, F_SWITCH), 32'h0);
		wr(la(l, F_CODE), {24'h0, code});
		wr(la(l, F_TBSEL), {29'h0, TB_ZERO});
		wr(la(l, F_POLARITY), {31'h0, pol});
		wr(la(l, F_SWITCH), 32'h1);
	endtask

	// Start falls on line 0, stop rises on line 1, separated by k+5 clocks; then lines go idle.
	task automatic measure(input int k);
		eiac_line_model_i.setLine(0, 1'b0);
		repeat (k) @(posedge clk);
		eiac_line_model_i.setLine(1, 1'b1);
		eiac_line_model_i.setLine(0, 1'b1);
		eiac_line_model_i.setLine(1, 1'b0);
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Guards against a hang; the tests need roughly seventeen hundred clocks.
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		streamActive = 1'b0;
		regAddr = 16'h0;
		regRead = 1'b0;
		regWrite = 1'b0;
		regWdata = 32'h0;
		miscompares = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// System tick over 99 clocks, about 15.8 ticks at 40 MHz.
		rd(ADDR_SYS_TICK, a);
		repeat (97) @(posedge clk);
		rd(ADDR_SYS_TICK, b);
		chkRange("system tick step", b - a, 32'd14, 32'd17);
		rd(16'h1234, a);
		chk("unmapped read", a, 32'h0);
		for (int t = 0; t < NUM_TB; t++) begin
			wr(la(2, F_TBSEL), {29'h0, 3'(t)});
			rd(la(2, F_TBSEL), a);
			chk("timebase select", a, 32'(t));
		end
		// Timebase zero at full core rate with full range.
		wr(ta(0, F_TB_DIVISOR), 32'h0);
		wr(ta(0, F_TB_WRAP), 32'h0);
		wr(ta(0, F_TB_ENABLE), 32'h1);
		wr(la(0, F_SWITCH), 32'h0);
		wr(la(1, F_SWITCH), 32'h0);
		cfg(0, FC_INTERVAL, 1'b0);
		cfg(1, FC_INTERVAL, 1'b1);
		eiac_line_model_i.pulse(1);
		rd(la(0, F_RESULT), a);
		chk("result before pair", a, 32'h0);
		wr(la(0, F_POLARITY), 32'h1);
		rd(la(0, F_POLARITY), a);
		chk("frozen polarity", a, 32'h0);
		// Thirteen clocks is about 52 ns, some 4.2 ticks.
		measure(8);
		rd(la(0, F_RESULT), a);
		chkRange("short interval", a, 32'd3, 32'd5);
		rd(la(1, F_RESULT), b);
		chk("second line result", b, a);
		rd(la(0, F_RESULT_RC), c);
		chk("read clear value", c, a);
		rd(la(0, F_RESULT), c);
		chk("result after clear", c, 32'h0);
		// Divisor 8 over 1000 clocks gives 40 ticks.
		wr(ta(0, F_TB_ENABLE), 32'h0);
		wr(ta(0, F_TB_DIVISOR), 32'h8);
		wr(ta(0, F_TB_ENABLE), 32'h1);
		measure(995);
		rd(la(0, F_RESULT), a);
		chkRange("long interval", a, 32'd39, 32'd41);
		rd(la(1, F_RESULT), b);
		chk("second line long", b, a);
		s = (64'(a) * 64'd8 * 64'd65536) / 64'd80000000;
		rd(la(0, F_RESULT_SEC), c);
		chkRange("seconds", c + 32'd1, s[31:0], s[31:0] + 32'd2);
		measure(100);
		rd(la(0, F_RESULT), b);
		chk("one shot hold", b, a);
		// Tallies with timebase zero running and streaming on, then with both off.
		for (int l = 4; l < 8; l++) cfg(l, FC_TALLY, 1'b0);
		@(posedge clk);
		streamActive <= 1'b1;
		for (int l = 4; l < 8; l++) repeat (2) eiac_line_model_i.pulse(l);
		for (int l = 4; l < 8; l++) begin
			rd(la(l, F_RESULT), a);
			chk("shared tally", a, e1[l-4]);
		end
		wr(ta(0, F_TB_ENABLE), 32'h0);
		@(posedge clk);
		streamActive <= 1'b0;
		for (int l = 4; l < 8; l++) repeat (2) eiac_line_model_i.pulse(l);
		for (int l = 4; l < 8; l++) begin
			rd(la(l, F_RESULT), a);
			chk("free tally", a, e2[l-4]);
		end
		rd(la(6, F_RESULT_RC), a);
		chk("tally read clear", a, 32'h4);
		rd(la(6, F_RESULT), a);
		chk("tally after clear", a, 32'h0);
		// Edge counter on line 3, read back while streaming.
		cfg(3, FC_IRQ_CNT, 1'b0);
		repeat (3) eiac_line_model_i.pulse(3);
		@(posedge clk);
		streamActive <= 1'b1;
		rd(la(3, F_RESULT), a);
		chk("edge counter", a, 32'h3);
		rd(ADDR_CAPTURE, a);
		chk("capture high half", a, 32'h0);
		report_and_stop();
	end

endmodule
